// ==== psf_status_word.sv ====
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module psf_status_word #(
  parameter int unsigned ADDR_W = psf_pkg::APB_ADDR_W
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             opValid,
  input  wire psf_pkg::psf_op_t opCode,
  input  wire logic [7:0]       opA,
  input  wire logic [7:0]       opB,
  input  wire logic             bitOperand,
  input  wire logic [7:0]       accumulator,
  input  wire logic [2:0]       regIndex,
  output logic [7:0]            statusWord,
  output logic                  carryFlag,
  output logic [1:0]            bankSelect,
  output logic [7:0]            regAddress
);

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  logic       carry_q;
  logic       carry_d;
  logic       half_q;
  logic       half_d;
  logic       user0_q;
  logic       user0_d;
  logic [1:0] bank_q;
  logic [1:0] bank_d;
  logic       ovfl_q;
  logic       ovfl_d;
  logic       user1_q;
  logic       user1_d;
  logic       parity_q;
  logic       parity_d;
  logic [7:0] regAddr_q;
  logic [7:0] regAddr_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // ---------------------------------------------------------------------
  // register bus decode
  // ---------------------------------------------------------------------
  logic       addrHit;
  logic       swWrite;
  logic [7:0] swData;
  logic [7:0] wordNow;

  function automatic logic is_status_addr(input logic [ADDR_W-1:0] a);
    return a == ADDR_W'(psf_pkg::STATUS_WORD_ADDR);
  endfunction

  always_comb begin
    addrHit = is_status_addr(paddr);
    swWrite = psel && penable && pwrite && addrHit && pstrb[0];
    swData  = pwdata[7:0];
    pready  = 1'b1;
    pslverr = psel && penable && !addrHit;
  end

  // ---------------------------------------------------------------------
  // shared adder for add, add with carry and subtract with borrow
  // ---------------------------------------------------------------------
  psf_adder_if addBus ();

  always_comb begin
    addBus.opA      = opA;
    addBus.opB      = opB;
    addBus.carryIn  = (opCode != psf_pkg::OP_ADD) && carry_q;
    addBus.subtract = opCode == psf_pkg::OP_SUBB;
  end

  psf_add_unit addUnit (
    .port (addBus.unit)
  );

  // ---------------------------------------------------------------------
  // instruction flag results
  // ---------------------------------------------------------------------
  // decimal adjust only ever sets carry, never clears it
  logic [15:0] product;
  logic        lowAdjust;
  logic [8:0]  daFirst;
  logic        daCarry;
  logic        highAdjust;
  logic [8:0]  daSecond;
  logic        daCarryOut;

  always_comb begin
    product    = {8'h00, opA} * {8'h00, opB};
    lowAdjust  = (opA[3:0] > psf_pkg::BCD_DIGIT_MAX) || half_q;
    daFirst    = {1'b0, opA}
               + {1'b0, lowAdjust ? psf_pkg::BCD_LOW_ADJ : 8'h00};
    daCarry    = carry_q || daFirst[8];
    highAdjust = (daFirst[7:4] > psf_pkg::BCD_DIGIT_MAX) || daCarry;
    daSecond   = {1'b0, daFirst[7:0]}
               + {1'b0, highAdjust ? psf_pkg::BCD_HIGH_ADJ : 8'h00};
    daCarryOut = daCarry || daSecond[8];
  end

  // per-operation results plus which flags that operation may touch
  logic opCarryEn;
  logic opCarryVal;
  logic opHalfEn;
  logic opHalfVal;
  logic opOvflEn;
  logic opOvflVal;

  always_comb begin
    opCarryEn  = 1'b0;
    opCarryVal = carry_q;
    opHalfEn   = 1'b0;
    opHalfVal  = half_q;
    opOvflEn   = 1'b0;
    opOvflVal  = ovfl_q;
    unique case (opCode)
      psf_pkg::OP_NONE: begin
      end
      psf_pkg::OP_ADD, psf_pkg::OP_ADDC, psf_pkg::OP_SUBB: begin
        opCarryEn  = 1'b1;
        opCarryVal = addBus.carryOut;
        opHalfEn   = 1'b1;
        opHalfVal  = addBus.halfCarry;
        opOvflEn   = 1'b1;
        opOvflVal  = addBus.overflow;
      end
      psf_pkg::OP_MUL: begin
        opCarryEn  = 1'b1;
        opCarryVal = 1'b0;
        opOvflEn   = 1'b1;
        opOvflVal  = product[15:8] != 8'h00;
      end
      psf_pkg::OP_DIV: begin
        opCarryEn  = 1'b1;
        opCarryVal = 1'b0;
        opOvflEn   = 1'b1;
        opOvflVal  = opB == 8'h00;
      end
      psf_pkg::OP_DA: begin
        opCarryEn  = 1'b1;
        opCarryVal = daCarryOut;
      end
      psf_pkg::OP_RRC: begin
        opCarryEn  = 1'b1;
        opCarryVal = opA[0];
      end
      psf_pkg::OP_RLC: begin
        opCarryEn  = 1'b1;
        opCarryVal = opA[7];
      end
      psf_pkg::OP_SETBC: begin
        opCarryEn  = 1'b1;
        opCarryVal = 1'b1;
      end
      psf_pkg::OP_CLRC: begin
        opCarryEn  = 1'b1;
        opCarryVal = 1'b0;
      end
      psf_pkg::OP_CPLC: begin
        opCarryEn  = 1'b1;
        opCarryVal = !carry_q;
      end
      psf_pkg::OP_ANLC: begin
        opCarryEn  = 1'b1;
        opCarryVal = carry_q && bitOperand;
      end
      psf_pkg::OP_ANLCN: begin
        opCarryEn  = 1'b1;
        opCarryVal = carry_q && !bitOperand;
      end
      psf_pkg::OP_ORLC: begin
        opCarryEn  = 1'b1;
        opCarryVal = carry_q || bitOperand;
      end
      psf_pkg::OP_ORLCN: begin
        opCarryEn  = 1'b1;
        opCarryVal = carry_q || !bitOperand;
      end
      psf_pkg::OP_MOVC: begin
        opCarryEn  = 1'b1;
        opCarryVal = bitOperand;
      end
      psf_pkg::OP_CJNE: begin
        opCarryEn  = 1'b1;
        opCarryVal = opA < opB;
      end
      default: begin
      end
    endcase
  end

  // ---------------------------------------------------------------------
  // flag next state
  // ---------------------------------------------------------------------
  // a same-cycle instruction update beats a software write on the flags
  // that instruction owns; software still lands on the other bits except parity
  always_comb begin
    carry_d = carry_q;
    half_d  = half_q;
    user0_d = user0_q;
    bank_d  = bank_q;
    ovfl_d  = ovfl_q;
    user1_d = user1_q;
    if (swWrite) begin
      carry_d = swData[psf_pkg::CARRY_BIT];
      half_d  = swData[psf_pkg::HALF_BIT];
      user0_d = swData[psf_pkg::USER0_BIT];
      bank_d  = swData[psf_pkg::BANK_HI_BIT:psf_pkg::BANK_LO_BIT];
      ovfl_d  = swData[psf_pkg::OVFL_BIT];
      user1_d = swData[psf_pkg::USER1_BIT];
    end
    if (opValid && opCarryEn) begin
      carry_d = opCarryVal;
    end
    if (opValid && opHalfEn) begin
      half_d = opHalfVal;
    end
    if (opValid && opOvflEn) begin
      ovfl_d = opOvflVal;
    end
    // parity ignores writes and tracks the accumulator one cycle behind
    parity_d  = ^accumulator;
    regAddr_d = {3'h0, bank_q, regIndex};
  end

  // ---------------------------------------------------------------------
  // read data, captured in the setup phase so prdata comes from a flop
  // ---------------------------------------------------------------------
  always_comb begin
    wordNow = 8'h00;
    wordNow[psf_pkg::CARRY_BIT]  = carry_q;
    wordNow[psf_pkg::HALF_BIT]   = half_q;
    wordNow[psf_pkg::USER0_BIT]  = user0_q;
    wordNow[psf_pkg::BANK_HI_BIT:psf_pkg::BANK_LO_BIT] = bank_q;
    wordNow[psf_pkg::OVFL_BIT]   = ovfl_q;
    wordNow[psf_pkg::USER1_BIT]  = user1_q;
    wordNow[psf_pkg::PARITY_BIT] = parity_q;
    rdata_d = rdata_q;
    if (psel && !penable) begin
      rdata_d = addrHit ? wordNow : 8'h00;
    end
  end

  // ---------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      carry_q   <= psf_pkg::STATUS_WORD_RESET[psf_pkg::CARRY_BIT];
      half_q    <= psf_pkg::STATUS_WORD_RESET[psf_pkg::HALF_BIT];
      user0_q   <= psf_pkg::STATUS_WORD_RESET[psf_pkg::USER0_BIT];
      bank_q    <= psf_pkg::STATUS_WORD_RESET[
                     psf_pkg::BANK_HI_BIT:psf_pkg::BANK_LO_BIT];
      ovfl_q    <= psf_pkg::STATUS_WORD_RESET[psf_pkg::OVFL_BIT];
      user1_q   <= psf_pkg::STATUS_WORD_RESET[psf_pkg::USER1_BIT];
      parity_q  <= psf_pkg::STATUS_WORD_RESET[psf_pkg::PARITY_BIT];
      regAddr_q <= 8'h00;
      rdata_q   <= 8'h00;
    end else begin
      carry_q   <= carry_d;
      half_q    <= half_d;
      user0_q   <= user0_d;
      bank_q    <= bank_d;
      ovfl_q    <= ovfl_d;
      user1_q   <= user1_d;
      parity_q  <= parity_d;
      regAddr_q <= regAddr_d;
      rdata_q   <= rdata_d;
    end
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  always_comb begin
    prdata     = {24'h00_0000, rdata_q};
    statusWord = wordNow;
    carryFlag  = carry_q;
    bankSelect = bank_q;
    regAddress = regAddr_q;
  end

endmodule // psf_status_word
`default_nettype wire

// ==== psf_pkg.sv ====
package psf_pkg;

  // ---------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------
  localparam int unsigned APB_ADDR_W        = 12;
  localparam int unsigned APB_DATA_W        = 32;
  localparam logic [11:0] STATUS_WORD_ADDR  = 12'h0d0;
  localparam logic [7:0]  STATUS_WORD_RESET = 8'h00;
  localparam logic [7:0]  SW_WRITE_MASK     = 8'hfe;

  // ---------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------
  localparam int unsigned CARRY_BIT   = 7;
  localparam int unsigned HALF_BIT    = 6;
  localparam int unsigned USER0_BIT   = 5;
  localparam int unsigned BANK_HI_BIT = 4;
  localparam int unsigned BANK_LO_BIT = 3;
  localparam int unsigned OVFL_BIT    = 2;
  localparam int unsigned USER1_BIT   = 1;
  localparam int unsigned PARITY_BIT  = 0;

  // ---------------------------------------------------------------------
  // decimal adjust constants
  // ---------------------------------------------------------------------
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0] BCD_LOW_ADJ   = 8'h06;
  localparam logic [7:0] BCD_HIGH_ADJ  = 8'h60;

  // ---------------------------------------------------------------------
  // flag-affecting operations issued by the sequencer
  // ---------------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NONE  = 5'b00000,
    OP_ADD   = 5'b00001,
    OP_ADDC  = 5'b00010,
    OP_SUBB  = 5'b00011,
    OP_MUL   = 5'b00100,
    OP_DIV   = 5'b00101,
    OP_DA    = 5'b00110,
    OP_RRC   = 5'b00111,
    OP_RLC   = 5'b01000,
    OP_SETBC = 5'b01001,
    OP_CLRC  = 5'b01010,
    OP_CPLC  = 5'b01011,
    OP_ANLC  = 5'b01100,
    OP_ANLCN = 5'b01101,
    OP_ORLC  = 5'b01110,
    OP_ORLCN = 5'b01111,
    OP_MOVC  = 5'b10000,
    OP_CJNE  = 5'b10001
  } psf_op_t;

endpackage

// ==== psf_adder_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface psf_adder_if;
  logic [7:0] opA;
  logic [7:0] opB;
  logic       carryIn;
  logic       subtract;
  logic       carryOut;
  logic       halfCarry;
  logic       overflow;

  modport core (
    output opA,
    output opB,
    output carryIn,
    output subtract,
    input  carryOut,
    input  halfCarry,
    input  overflow
  );

  modport unit (
    input  opA,
    input  opB,
    input  carryIn,
    input  subtract,
    output carryOut,
    output halfCarry,
    output overflow
  );
endinterface
`default_nettype wire

// ==== psf_add_unit.sv ====
`timescale 1ns/10ps
`default_nettype none
module psf_add_unit (
  psf_adder_if.unit port
);
  // subtraction as a + ~b + ~borrow, carries inverted back into borrows
  logic [7:0] bEff;
  logic       cEff;
  logic [4:0] lowSum;
  logic [7:0] midSum;
  logic [8:0] fullSum;

  always_comb begin
    bEff    = port.subtract ? ~port.opB : port.opB;
    cEff    = port.subtract ? ~port.carryIn : port.carryIn;
    lowSum  = {1'b0, port.opA[3:0]} + {1'b0, bEff[3:0]} + {4'h0, cEff};
    midSum  = {1'b0, port.opA[6:0]} + {1'b0, bEff[6:0]} + {7'h00, cEff};
    fullSum = {1'b0, port.opA} + {1'b0, bEff} + {8'h00, cEff};
    port.carryOut  = fullSum[8] ^ port.subtract;
    port.halfCarry = lowSum[4] ^ port.subtract;
    port.overflow  = midSum[7] ^ fullSum[8];
  end
endmodule // psf_add_unit
`default_nettype wire

// ==== psf_core_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------
// sequencer side of the op port
// ---------------------------------------------------------------------
// the accumulator takes the sum on an add, the operand on any other request, and holds without one;
// operands read back inverted while no op is offered, never stale
module psf_core_model (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             reqValid,
  input  wire psf_pkg::psf_op_t reqCode,
  input  wire logic [7:0]       reqA,
  input  wire logic [7:0]       reqB,
  output logic                  opValid,
  output psf_pkg::psf_op_t      opCode,
  output logic [7:0]            opA,
  output logic [7:0]            opB,
  output logic [7:0]            accumulator
);
  logic [7:0] acc_d;
  logic [7:0] acc_q;

  always_comb begin
    acc_d = acc_q;
    if (!resetn) begin
      acc_d = 8'h00;
    end else if (reqValid) begin
      acc_d = (reqCode == psf_pkg::OP_ADD) ? reqA + reqB : reqA;
    end
  end

  always_ff @(posedge clock) begin
    acc_q <= acc_d;
  end

  assign opValid     = reqValid;
  assign opCode      = reqValid ? reqCode : psf_pkg::OP_NONE;
  assign opA         = reqValid ? reqA : ~reqA;
  assign opB         = reqValid ? reqB : ~reqB;
  assign accumulator = acc_q;
endmodule // psf_core_model
`default_nettype wire

// ==== psf_status_word_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module psf_status_word_checker #(
  parameter int unsigned ADDR_W = psf_pkg::APB_ADDR_W
) (
  input wire logic              clock,
  input wire logic              resetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pslverr,
  input wire logic              opValid,
  input wire psf_pkg::psf_op_t  opCode,
  input wire logic [7:0]        opA,
  input wire logic [7:0]        opB,
  input wire logic [7:0]        accumulator,
  input wire logic [2:0]        regIndex,
  input wire logic [7:0]        statusWord,
  input wire logic              carryFlag,
  input wire logic [1:0]        bankSelect,
  input wire logic [7:0]        regAddress
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  logic       wrMap;
  logic [8:0] addSum;
  assign wrMap = psel && penable && pwrite && pstrb[0]
      && paddr == ADDR_W'(psf_pkg::STATUS_WORD_ADDR);
  assign addSum = {1'b0, opA} + {1'b0, opB};

  sequence sOp(psf_pkg::psf_op_t c);
    opValid && opCode == c;
  endsequence
  sequence sAccess;
    psel && penable;
  endsequence

  a_add_carry: assert property (
    sOp(psf_pkg::OP_ADD) |=> carryFlag == $past(addSum[8]))
    else $error("carry wrong after add");
  a_clear_carry: assert property (
    sOp(psf_pkg::OP_CLRC) |=> !carryFlag) else $error("carry not cleared");
  a_mul_ovfl: assert property (
    sOp(psf_pkg::OP_MUL) |=> !carryFlag
      && statusWord[2] == ($past(opA) * $past(opB) > 255))
    else $error("multiply flags wrong");
  a_parity_track: assert property (
    $past(resetn) |-> statusWord[0] == ^$past(accumulator))
    else $error("parity does not follow accumulator");
  a_bank_mirror: assert property (
    !wrMap |=> $stable(bankSelect))
    else $error("bank select moved without a software write");
  a_reg_address: assert property (
    $past(resetn) |->
      regAddress == {3'b000, $past(bankSelect), $past(regIndex)})
    else $error("working register address wrong");
  a_user_write: assert property (
    wrMap && !opValid |=> statusWord[7:1] == $past(pwdata[7:1]))
    else $error("write not taken");
  a_idle_hold: assert property (
    !opValid && !wrMap |=> $stable(statusWord[7:1]))
    else $error("flags changed without cause");
  a_err_unmapped: assert property (
    sAccess |-> pslverr == (paddr != ADDR_W'(psf_pkg::STATUS_WORD_ADDR)))
    else $error("slave error wrong");
endmodule // psf_status_word_checker

bind psf_status_word psf_status_word_checker #(.ADDR_W(ADDR_W)) u_chk (
  .clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pslverr(pslverr), .opValid(opValid), .opCode(opCode), .opA(opA),
  .opB(opB), .accumulator(accumulator), .regIndex(regIndex),
  .statusWord(statusWord), .carryFlag(carryFlag),
  .bankSelect(bankSelect), .regAddress(regAddress));
`default_nettype wire

// ==== tb_processor_status_flags.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_processor_status_flags;
  logic             clock = 1'b0, resetn = 1'b0, psel = 1'b0;
  logic             penable = 1'b0, pwrite = 1'b0, reqValid = 1'b0;
  logic             bitOperand = 1'b0, pready, pslverr, opValid, err;
  logic             carryFlag;
  logic [11:0]      paddr = 12'h000;
  logic [31:0]      pwdata = 32'h0000_0000, prdata, rd, r;
  logic [31:0]      seed = 32'h0000_002b;
  logic [3:0]       pstrb = 4'h0;
  logic [7:0]       reqA = 8'h00, reqB = 8'h00, opA, opB, accumulator;
  logic [7:0]       statusWord, regAddress, expQ = 8'h00;
  logic [2:0]       regIndex = 3'h0;
  logic [1:0]       bankSelect;
  psf_pkg::psf_op_t reqCode = psf_pkg::OP_NONE, opCode;
  int               mismatches = 0, comparisons = 0;
  localparam logic [11:0] SW = psf_pkg::STATUS_WORD_ADDR;

  initial begin
    forever #25 clock = ~clock;
  end

  psf_core_model core (.clock(clock), .resetn(resetn), .reqValid(reqValid),
    .reqCode(reqCode), .reqA(reqA), .reqB(reqB), .opValid(opValid),
    .opCode(opCode), .opA(opA), .opB(opB), .accumulator(accumulator));
  psf_status_word DUT (.clock(clock), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .opValid(opValid), .opCode(opCode), .opA(opA), .opB(opB),
    .bitOperand(bitOperand), .accumulator(accumulator),
    .regIndex(regIndex), .statusWord(statusWord), .carryFlag(carryFlag),
    .bankSelect(bankSelect), .regAddress(regAddress));

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected flags after one op; only the bits the op owns move
  function automatic logic [7:0] exp_flags(psf_pkg::psf_op_t c,
      logic [7:0] a, logic [7:0] b, logic bt, logic [7:0] s);
    logic [8:0] t;
    logic [4:0] h;
    logic       ci;
    ci = s[7] && c != psf_pkg::OP_ADD;
    case (c)
      psf_pkg::OP_ADD, psf_pkg::OP_ADDC: begin
        t = a + b + ci;
        h = a[3:0] + b[3:0] + ci;
        s[7:6] = {t[8], h[4]};
        s[2] = a[7] == b[7] && t[7] != a[7];
      end
      psf_pkg::OP_SUBB: begin
        t = a - b - ci;
        h = a[3:0] - b[3:0] - ci;
        s[7:6] = {t[8], h[4]};
        s[2] = a[7] != b[7] && t[7] != a[7];
      end
      psf_pkg::OP_MUL: s[7] = 1'b0;
      psf_pkg::OP_DIV: s[7] = 1'b0;
      psf_pkg::OP_DA: begin
        t = {1'b0, a};
        if (t[3:0] > 4'h9 || s[6]) t = t + 9'h006;
        s[7] = s[7] | t[8];
        if (t[7:4] > 4'h9 || s[7]) t = t + 9'h060;
        s[7] = s[7] | t[8];
      end
      psf_pkg::OP_RRC:   s[7] = a[0];
      psf_pkg::OP_RLC:   s[7] = a[7];
      psf_pkg::OP_SETBC: s[7] = 1'b1;
      psf_pkg::OP_CLRC:  s[7] = 1'b0;
      psf_pkg::OP_CPLC:  s[7] = ~s[7];
      psf_pkg::OP_ANLC:  s[7] = s[7] & bt;
      psf_pkg::OP_ANLCN: s[7] = s[7] & ~bt;
      psf_pkg::OP_ORLC:  s[7] = s[7] | bt;
      psf_pkg::OP_ORLCN: s[7] = s[7] | ~bt;
      psf_pkg::OP_MOVC:  s[7] = bt;
      psf_pkg::OP_CJNE:  s[7] = a < b;
      default: ;
    endcase
    if (c == psf_pkg::OP_MUL) s[2] = {8'h00, a} * {8'h00, b} > 16'h00ff;
    if (c == psf_pkg::OP_DIV) s[2] = b == 8'h00;
    return s;
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clock);
    {psel, penable, pwrite, reqValid} <= {1'b1, 1'b0, w, 1'b0};
    {paddr, pwdata, pstrb} <= {a, d, s};
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      mismatches++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (w && a == SW && s[0]) expQ = {d[7:1], 1'b0};
  endtask

  // offers the next op at the edge, then checks the previous one mid-cycle
  // where the flag registers have settled
  task automatic op(input psf_pkg::psf_op_t c, input logic [7:0] a,
      input logic [7:0] b, input logic bt);
    @(posedge clock);
    reqValid   <= 1'b1;
    reqCode    <= c;
    reqA       <= a;
    reqB       <= b;
    bitOperand <= bt;
    @(negedge clock);
    cmp(statusWord[7:1], expQ[7:1]);
    cmp(carryFlag, expQ[7]);
    expQ = exp_flags(c, a, b, bt, expQ);
  endtask

  initial begin
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    apb(1'b0, SW, 32'h0000_0000, 4'h0);
    cmp(rd, 32'h0000_0000);
    apb(1'b1, 12'h0d4, 32'hffff_ffff, 4'hf);
    apb(1'b0, 12'h0d4, 32'h0000_0000, 4'h0);
    cmp({rd[30:0], err}, 32'h0000_0001);
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      regIndex <= r[22:20];
      op(psf_pkg::OP_NONE, r[7:0], r[15:8], r[16]);
      apb(1'b1, SW, r, {r[27:25], r[16] | (i < 2)});
      apb(1'b0, SW, 32'h0000_0000, 4'h0);
      cmp(rd, {24'h00_0000, expQ[7:1], ^accumulator});
      cmp(regAddress, {3'b000, expQ[4:3], regIndex});
      cmp(bankSelect, expQ[4:3]);
    end
    for (int k = 0; k < 18; k++) begin
      for (int i = 0; i < 8; i++) begin
        r = rnd();
        op(psf_pkg::psf_op_t'(k), (i == 0) ? 8'hff : r[7:0],
           (i == 0) ? 8'h01 : (i == 1) ? 8'h00 : r[15:8], r[16]);
      end
    end
    op(psf_pkg::OP_NONE, 8'h00, 8'h00, 1'b0);
    op(psf_pkg::OP_NONE, 8'h00, 8'h00, 1'b0);
    print_verdict();
  end
endmodule // tb_processor_status_flags
`default_nettype wire
